//--- design/pts_pkg.sv
// constants and types shared by both ends of the position transmit scheduler link
package pts_pkg;
	localparam int ID_W = 11;
	localparam int DATA_W = 64;
	localparam int POS_W = 32;
	localparam int CLK_HZ = 100_000_000;
	localparam int MS_TIME = 1;
	localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
	localparam int FRAME_CYCLES = 8;
	localparam int FIFO_DEPTH = 32;
	localparam logic [10:0] FC_NMT = 11'h000;
	localparam logic [10:0] FC_SYNC = 11'h080;
	localparam logic [10:0] FC_POS = 11'h180;
	localparam logic [10:0] FC_SDO_TX = 11'h580;
	localparam logic [10:0] FC_SDO_RX = 11'h600;
	localparam logic [3:0] MAX_DLC = 4'h8;
	localparam logic [3:0] POS_DLC = 4'h4;
	localparam logic [6:0] MAX_NODES = 7'h7f;
	localparam logic [2:0] SDO_WR_CCS = 3'h1;
	localparam logic [7:0] SDO_WR_CMD = 8'h23;
	localparam logic [7:0] SDO_ACK = 8'h60;
	localparam logic [7:0] SDO_ABORT = 8'h80;
	localparam logic [31:0] SDO_ABORT_CODE = 32'h0609_0030;
	localparam logic [7:0] NMT_RESET_NODE = 8'h81;
	localparam logic [7:0] NMT_RESET_COMM = 8'h82;
	localparam logic [15:0] IDX_NODE = 16'h3000;
	localparam logic [15:0] IDX_TERM = 16'h3002;
	localparam logic [15:0] IDX_MODE = 16'h3010;
	localparam logic [15:0] IDX_SYNC_DIV = 16'h3011;
	localparam logic [15:0] IDX_CYCLE = 16'h6200;
	localparam logic [7:0] ADDR_RST = 8'h1f;
	localparam logic TERM_RST = 1'b0;
	localparam logic [15:0] CYCLE_RST = 16'h0064;
	localparam logic [7:0] SYNC_DIV_RST = 8'h01;
	typedef enum logic [1:0] {PTS_POLLED, PTS_CYCLIC, PTS_SYNC} pts_mode_type;
	typedef enum logic [1:0] {PTS_CMD_SYNC, PTS_CMD_RTR, PTS_CMD_SDO, PTS_CMD_NMT} pts_cmd_type;
endpackage : pts_pkg

//--- design/pts_link_if.sv
// shared-bus link between the encoder channel and the bus master end
interface pts_link_if (
	input wire logic clk,
	input wire logic nrst
);
	// frames from the master end, seen by every node
	logic m_valid;
	logic m_rtr;
	logic [10:0] m_id;
	logic [3:0] m_dlc;
	logic [63:0] m_data;
	// frame offered by the encoder channel
	logic d_valid;
	logic [10:0] d_id;
	logic [3:0] d_dlc;
	logic [63:0] d_data;
	// arbitration
	logic d_ack;
	logic bus_busy;
	modport device (
		input m_valid, m_rtr, m_id, m_dlc, m_data, d_ack, bus_busy,
		output d_valid, d_id, d_dlc, d_data
	);
	modport master (
		output m_valid, m_rtr, m_id, m_dlc, m_data, d_ack, bus_busy,
		input d_valid, d_id, d_dlc, d_data
	);
endinterface : pts_link_if

//--- design/pts_device.sv
// encoder channel end: configuration objects, transmit triggers, position fifo and bus access
module pts_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d;
	logic push, pop;

	assign in_ready_out = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_valid_out = (wr_q != rd_q);
	assign out_data_out = mem_q[rd_q[AW-1:0]];

	always_comb begin
		push = in_valid_in && in_ready_out;
		pop = out_valid_out && out_ready_in;
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_in;
		end
	end
endmodule : pts_fifo

// What this block does
// - polled mode sends only on remote request
// - cyclic mode sends at configured period
// - sync mode sends every n-th sync
// - frame is identifier plus at most eight bytes
// - identifier is function code plus node number
// - send when bus free, lowest identifier wins
// - object 3002h switches line terminator
// - node numbers stay within 127
// - effective node is address plus one
// - new configuration adopted only at reset
module pts_device #(
	parameter int MS_CYCLES_P = pts_pkg::MS_CYCLES,
	parameter int DEPTH = pts_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// bus link
	pts_link_if.device link,
	// position source
	input wire logic [31:0] pos_in,
	// active configuration
	output logic term_en_out,
	output logic [6:0] node_out,
	output pts_pkg::pts_mode_type mode_out
);
	typedef enum {PTS_TX_IDLE, PTS_TX_WAIT} pts_tx_type;

	pts_tx_type tx_q, tx_d;
	pts_pkg::pts_mode_type mode_q, mode_d, nv_mode_q, nv_mode_d;
	logic [6:0] node_q, node_d;
	logic term_q, term_d, nv_term_q, nv_term_d;
	logic [7:0] nv_addr_q, nv_addr_d, div_q, div_d, nv_div_q, nv_div_d, sync_cnt_q, sync_cnt_d;
	logic [15:0] cycle_q, cycle_d, nv_cycle_q, nv_cycle_d, per_cnt_q, per_cnt_d;
	logic [31:0] ms_cnt_q, ms_cnt_d, pend_pos_q, pend_pos_d, rsp_val_q, rsp_val_d;
	logic pend_q, pend_d, rsp_pend_q, rsp_pend_d;
	logic [7:0] rsp_cmd_q, rsp_cmd_d;
	logic [23:0] rsp_mux_q, rsp_mux_d;
	logic d_valid_q, d_valid_d;
	logic [10:0] d_id_q, d_id_d;
	logic [3:0] d_dlc_q, d_dlc_d;
	logic [63:0] d_data_q, d_data_d;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [31:0] fifo_out_data;
	logic rx_ok, is_sdo, is_nmt, is_rtr, is_sync, trig, ms_tick;
	logic [15:0] sdo_idx;
	logic [31:0] sdo_val;

	pts_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.in_valid_in(pend_q),
		.in_ready_out(fifo_in_ready),
		.in_data_in(pend_pos_q),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_out_ready),
		.out_data_out(fifo_out_data)
	);

	// frames longer than eight bytes are ignored
	assign rx_ok = link.m_valid && (link.m_dlc <= pts_pkg::MAX_DLC);
	assign is_sdo = rx_ok && !link.m_rtr && (link.m_dlc == pts_pkg::MAX_DLC)
		&& (link.m_id == pts_pkg::FC_SDO_RX + 11'(node_q))
		&& (link.m_data[7:5] == pts_pkg::SDO_WR_CCS);
	assign is_nmt = rx_ok && !link.m_rtr && (link.m_id == pts_pkg::FC_NMT)
		&& ((link.m_data[7:0] == pts_pkg::NMT_RESET_NODE)
		|| (link.m_data[7:0] == pts_pkg::NMT_RESET_COMM))
		&& ((link.m_data[15:8] == 8'h00) || (link.m_data[15:8] == {1'b0, node_q}));
	assign is_rtr = rx_ok && link.m_rtr && (link.m_id == pts_pkg::FC_POS + 11'(node_q));
	assign is_sync = rx_ok && !link.m_rtr && (link.m_id == pts_pkg::FC_SYNC);
	assign sdo_idx = link.m_data[23:8];
	assign sdo_val = link.m_data[63:32];
	assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES_P - 1));

	// a frame is offered only while the bus is free
	assign link.d_valid = d_valid_q && !link.bus_busy;
	assign link.d_id = d_id_q;
	assign link.d_dlc = d_dlc_q;
	assign link.d_data = d_data_q;
	assign term_en_out = term_q;
	assign node_out = node_q;
	assign mode_out = mode_q;

	always_comb begin
		{tx_d, mode_d, nv_mode_d, node_d, term_d, nv_term_d} =
			{tx_q, mode_q, nv_mode_q, node_q, term_q, nv_term_q};
		{nv_addr_d, div_d, nv_div_d, sync_cnt_d} = {nv_addr_q, div_q, nv_div_q, sync_cnt_q};
		{cycle_d, nv_cycle_d, per_cnt_d} = {cycle_q, nv_cycle_q, per_cnt_q};
		{pend_pos_d, rsp_val_d, pend_d, rsp_pend_d} = {pend_pos_q, rsp_val_q, pend_q, rsp_pend_q};
		{rsp_cmd_d, rsp_mux_d} = {rsp_cmd_q, rsp_mux_q};
		{d_valid_d, d_id_d, d_dlc_d, d_data_d} = {d_valid_q, d_id_q, d_dlc_q, d_data_q};
		fifo_out_ready = 1'b0;
		trig = 1'b0;
		ms_cnt_d = ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;

		// transmit stage: sdo answers go ahead of queued positions
		case (tx_q)
			PTS_TX_IDLE: begin
				if (rsp_pend_q) begin
					rsp_pend_d = 1'b0;
					d_valid_d = 1'b1;
					d_id_d = pts_pkg::FC_SDO_TX + 11'(node_q);
					d_dlc_d = pts_pkg::MAX_DLC;
					d_data_d = {rsp_val_q, rsp_mux_q, rsp_cmd_q};
					tx_d = PTS_TX_WAIT;
				end else if (fifo_out_valid) begin
					fifo_out_ready = 1'b1;
					d_valid_d = 1'b1;
					d_id_d = pts_pkg::FC_POS + 11'(node_q);
					d_dlc_d = pts_pkg::POS_DLC;
					d_data_d = {32'h0000_0000, fifo_out_data};
					tx_d = PTS_TX_WAIT;
				end
			end
			PTS_TX_WAIT: begin
				// a lost arbitration keeps the frame offered for a later retry
				if (link.d_ack) begin
					d_valid_d = 1'b0;
					tx_d = PTS_TX_IDLE;
				end
			end
			default: tx_d = PTS_TX_IDLE;
		endcase

		// configuration writes land in pending copies only
		if (is_sdo) begin
			rsp_pend_d = 1'b1;
			rsp_mux_d = link.m_data[31:8];
			rsp_cmd_d = pts_pkg::SDO_ACK;
			rsp_val_d = 32'h0000_0000;
			case (sdo_idx)
				pts_pkg::IDX_NODE: begin
					if (sdo_val < 32'(pts_pkg::MAX_NODES)) begin
						nv_addr_d = sdo_val[7:0];
					end else begin
						rsp_cmd_d = pts_pkg::SDO_ABORT;
					end
				end
				pts_pkg::IDX_TERM: nv_term_d = sdo_val[0];
				pts_pkg::IDX_MODE: begin
					if (sdo_val <= 32'(pts_pkg::PTS_SYNC)) begin
						nv_mode_d = pts_pkg::pts_mode_type'(sdo_val[1:0]);
					end else begin
						rsp_cmd_d = pts_pkg::SDO_ABORT;
					end
				end
				pts_pkg::IDX_SYNC_DIV: begin
					if ((sdo_val != 32'h0000_0000) && (sdo_val < 32'h0000_0100)) begin
						nv_div_d = sdo_val[7:0];
					end else begin
						rsp_cmd_d = pts_pkg::SDO_ABORT;
					end
				end
				pts_pkg::IDX_CYCLE: nv_cycle_d = sdo_val[15:0];
				default: rsp_cmd_d = pts_pkg::SDO_ABORT;
			endcase
			if (rsp_cmd_d == pts_pkg::SDO_ABORT) begin
				rsp_val_d = pts_pkg::SDO_ABORT_CODE;
			end
		end

		if (is_nmt) begin
			// reset adopts every pending value and restarts the timers
			node_d = 7'(nv_addr_q + 8'h01);
			term_d = nv_term_q;
			mode_d = nv_mode_q;
			div_d = nv_div_q;
			cycle_d = nv_cycle_q;
			sync_cnt_d = 8'h00;
			per_cnt_d = 16'h0000;
			ms_cnt_d = 32'h0000_0000;
		end else begin
			case (mode_q)
				pts_pkg::PTS_POLLED: trig = is_rtr;
				pts_pkg::PTS_CYCLIC: begin
					if (ms_tick && (cycle_q != 16'h0000)) begin
						if (per_cnt_q + 16'h0001 >= cycle_q) begin
							trig = 1'b1;
							per_cnt_d = 16'h0000;
						end else begin
							per_cnt_d = per_cnt_q + 16'h0001;
						end
					end
				end
				pts_pkg::PTS_SYNC: begin
					if (is_sync) begin
						if (sync_cnt_q + 8'h01 >= div_q) begin
							trig = 1'b1;
							sync_cnt_d = 8'h00;
						end else begin
							sync_cnt_d = sync_cnt_q + 8'h01;
						end
					end
				end
				default: trig = 1'b0;
			endcase
		end

		// a full fifo holds the snapshot back; a newer trigger replaces it
		if (pend_q && fifo_in_ready) begin
			pend_d = 1'b0;
		end
		if (trig) begin
			pend_d = 1'b1;
			pend_pos_d = pos_in;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_q <= PTS_TX_IDLE;
			mode_q <= pts_pkg::PTS_POLLED;
			nv_mode_q <= pts_pkg::PTS_POLLED;
			node_q <= 7'(pts_pkg::ADDR_RST + 8'h01);
			nv_addr_q <= pts_pkg::ADDR_RST;
			term_q <= pts_pkg::TERM_RST;
			nv_term_q <= pts_pkg::TERM_RST;
			div_q <= pts_pkg::SYNC_DIV_RST;
			nv_div_q <= pts_pkg::SYNC_DIV_RST;
			cycle_q <= pts_pkg::CYCLE_RST;
			nv_cycle_q <= pts_pkg::CYCLE_RST;
			sync_cnt_q <= 8'h00;
			per_cnt_q <= 16'h0000;
			ms_cnt_q <= 32'h0000_0000;
			pend_q <= 1'b0;
			pend_pos_q <= 32'h0000_0000;
			rsp_pend_q <= 1'b0;
			rsp_cmd_q <= 8'h00;
			rsp_mux_q <= 24'h00_0000;
			rsp_val_q <= 32'h0000_0000;
			d_valid_q <= 1'b0;
			d_id_q <= 11'h000;
			d_dlc_q <= 4'h0;
			d_data_q <= 64'h0;
		end else begin
			tx_q <= tx_d;
			mode_q <= mode_d;
			nv_mode_q <= nv_mode_d;
			node_q <= node_d;
			nv_addr_q <= nv_addr_d;
			term_q <= term_d;
			nv_term_q <= nv_term_d;
			div_q <= div_d;
			nv_div_q <= nv_div_d;
			cycle_q <= cycle_d;
			nv_cycle_q <= nv_cycle_d;
			sync_cnt_q <= sync_cnt_d;
			per_cnt_q <= per_cnt_d;
			ms_cnt_q <= ms_cnt_d;
			pend_q <= pend_d;
			pend_pos_q <= pend_pos_d;
			rsp_pend_q <= rsp_pend_d;
			rsp_cmd_q <= rsp_cmd_d;
			rsp_mux_q <= rsp_mux_d;
			rsp_val_q <= rsp_val_d;
			d_valid_q <= d_valid_d;
			d_id_q <= d_id_d;
			d_dlc_q <= d_dlc_d;
			d_data_q <= d_data_d;
		end
	end
endmodule : pts_device

//--- design/pts_master.sv
// bus master end: issues sync, remote requests, config writes and resets; arbitrates the bus
module pts_master #(
	parameter int FRAME_CYCLES = pts_pkg::FRAME_CYCLES
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// bus link
	pts_link_if.master link,
	// command port
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire pts_pkg::pts_cmd_type cmd_kind_in,
	input wire logic [6:0] cmd_node_in,
	input wire logic [15:0] cmd_index_in,
	input wire logic [31:0] cmd_value_in,
	// received frames
	output logic rx_valid_out,
	output logic [10:0] rx_id_out,
	output logic [3:0] rx_dlc_out,
	output logic [63:0] rx_data_out
);
	logic [7:0] busy_q, busy_d;
	logic m_valid_q, m_valid_d, m_rtr_q, m_rtr_d, rx_valid_q, rx_valid_d;
	logic [10:0] m_id_q, m_id_d, rx_id_q, rx_id_d, own_id;
	logic [3:0] m_dlc_q, m_dlc_d, rx_dlc_q, rx_dlc_d;
	logic [63:0] m_data_q, m_data_d, rx_data_q, rx_data_d;
	logic own_win, dev_win;

	assign link.bus_busy = (busy_q != 8'h00);
	assign link.m_valid = m_valid_q;
	assign link.m_rtr = m_rtr_q;
	assign link.m_id = m_id_q;
	assign link.m_dlc = m_dlc_q;
	assign link.m_data = m_data_q;
	assign rx_valid_out = rx_valid_q;
	assign rx_id_out = rx_id_q;
	assign rx_dlc_out = rx_dlc_q;
	assign rx_data_out = rx_data_q;

	always_comb begin
		case (cmd_kind_in)
			pts_pkg::PTS_CMD_SYNC: own_id = pts_pkg::FC_SYNC;
			pts_pkg::PTS_CMD_RTR: own_id = pts_pkg::FC_POS + 11'(cmd_node_in);
			pts_pkg::PTS_CMD_SDO: own_id = pts_pkg::FC_SDO_RX + 11'(cmd_node_in);
			default: own_id = pts_pkg::FC_NMT;
		endcase
		// lowest identifier wins a simultaneous start
		own_win = !link.bus_busy && cmd_valid_in && (!link.d_valid || (own_id < link.d_id));
		dev_win = !link.bus_busy && link.d_valid && !own_win;
		cmd_ready_out = own_win;
		link.d_ack = dev_win;
		busy_d = (busy_q != 8'h00) ? busy_q - 8'h01 : 8'h00;
		{m_valid_d, m_rtr_d, m_id_d, m_dlc_d, m_data_d} = {1'b0, m_rtr_q, m_id_q, m_dlc_q, m_data_q};
		{rx_valid_d, rx_id_d, rx_dlc_d, rx_data_d} = {1'b0, rx_id_q, rx_dlc_q, rx_data_q};
		if (own_win) begin
			busy_d = 8'(FRAME_CYCLES);
			m_valid_d = 1'b1;
			m_id_d = own_id;
			m_rtr_d = (cmd_kind_in == pts_pkg::PTS_CMD_RTR);
			case (cmd_kind_in)
				pts_pkg::PTS_CMD_SDO: begin
					m_dlc_d = pts_pkg::MAX_DLC;
					m_data_d = {cmd_value_in, 8'h00, cmd_index_in, pts_pkg::SDO_WR_CMD};
				end
				pts_pkg::PTS_CMD_NMT: begin
					m_dlc_d = 4'h2;
					m_data_d = {48'h0, 1'b0, cmd_node_in, pts_pkg::NMT_RESET_NODE};
				end
				default: begin
					m_dlc_d = 4'h0;
					m_data_d = 64'h0;
				end
			endcase
		end else if (dev_win) begin
			busy_d = 8'(FRAME_CYCLES);
			rx_valid_d = 1'b1;
			rx_id_d = link.d_id;
			rx_dlc_d = link.d_dlc;
			rx_data_d = link.d_data;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			busy_q <= 8'h00;
			{m_valid_q, m_rtr_q, m_id_q, m_dlc_q, m_data_q} <= '0;
			{rx_valid_q, rx_id_q, rx_dlc_q, rx_data_q} <= '0;
		end else begin
			busy_q <= busy_d;
			{m_valid_q, m_rtr_q, m_id_q, m_dlc_q, m_data_q} <= {m_valid_d, m_rtr_d, m_id_d, m_dlc_d, m_data_d};
			{rx_valid_q, rx_id_q, rx_dlc_q, rx_data_q} <= {rx_valid_d, rx_id_d, rx_dlc_d, rx_data_d};
		end
	end
endmodule : pts_master

//--- bench/pts_props.sv
// concurrent checks on the link between the two ends
module pts_props (
	// link clock and reset
	input wire logic clk,
	input wire logic nrst,
	// master frame
	input wire logic m_valid,
	input wire logic m_rtr,
	input wire logic [10:0] m_id,
	input wire logic [3:0] m_dlc,
	input wire logic [63:0] m_data,
	// device frame and arbitration
	input wire logic d_valid,
	input wire logic [10:0] d_id,
	input wire logic [3:0] d_dlc,
	input wire logic [63:0] d_data,
	input wire logic d_ack,
	input wire logic bus_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	sequence s_master_frame;
		m_valid;
	endsequence
	sequence s_busy_window;
		bus_busy [*8];
	endsequence
	sequence s_sdo_request;
		m_valid && !m_rtr && ((m_id & 11'h780) == pts_pkg::FC_SDO_RX);
	endsequence
	sequence s_sdo_answer;
		d_valid && d_ack && ((d_id & 11'h780) == pts_pkg::FC_SDO_TX);
	endsequence
	chk_busy_window: assert property (s_master_frame |-> s_busy_window)
		else $error("bus not held busy for a master frame");
	chk_busy_blocks: assert property (d_valid |-> !bus_busy)
		else $error("device offers while bus busy");
	chk_ack_offer: assert property (d_ack |-> d_valid)
		else $error("ack without offer");
	chk_one_sender: assert property (m_valid |-> !d_ack)
		else $error("two senders at once");
	chk_offer_holds: assert property (d_valid && !d_ack |=> $stable(d_id) && $stable(d_dlc)
		&& $stable(d_data))
		else $error("held frame changed before ack");
	chk_dev_dlc: assert property (d_valid |-> d_dlc <= pts_pkg::MAX_DLC)
		else $error("device frame too long");
	chk_mst_dlc: assert property (m_valid |-> m_dlc <= pts_pkg::MAX_DLC)
		else $error("master frame too long");
	chk_func_code: assert property (d_valid |-> ((d_id & 11'h780) == pts_pkg::FC_POS)
		|| ((d_id & 11'h780) == pts_pkg::FC_SDO_TX))
		else $error("device id has bad function code");
	chk_node_nonzero: assert property (d_valid |-> d_id[6:0] != 7'h00)
		else $error("device id carries node zero");
	chk_pos_format: assert property (d_valid && ((d_id & 11'h780) == pts_pkg::FC_POS)
		|-> d_dlc == pts_pkg::POS_DLC && d_data[63:32] == 32'h0000_0000)
		else $error("position frame badly formed");
	chk_sdo_reply: assert property (s_sdo_request |-> ##[2:40] s_sdo_answer)
		else $error("no answer to config write");
endmodule : pts_props

//--- bench/tb_top.sv
// self-checking bench joining the encoder channel and the bus master end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in;
	logic nrst_in;
	logic cmd_valid, cmd_ready_out, rx_valid_out, term_en_out;
	pts_pkg::pts_cmd_type cmd_kind;
	logic [6:0] cmd_node, node_out, cur_node;
	logic [15:0] cmd_index;
	logic [31:0] cmd_value, pos;
	logic [10:0] rx_id_out, lnk_id;
	logic [3:0] rx_dlc_out;
	logic [63:0] rx_data_out;
	pts_pkg::pts_mode_type mode_out;
	int mismatches = 0;
	int checks_done = 0;
	int rx_cnt = 0;
	int pos_cnt = 0;
	pts_link_if pts_link_if_inst (.clk(clk_in), .nrst(nrst_in));
	pts_device #(.MS_CYCLES_P(10), .DEPTH(pts_pkg::FIFO_DEPTH)) pts_device_inst (
		.clk_in(clk_in), .nrst_in(nrst_in), .link(pts_link_if_inst.device), .pos_in(pos),
		.term_en_out(term_en_out), .node_out(node_out), .mode_out(mode_out));
	pts_master #(.FRAME_CYCLES(pts_pkg::FRAME_CYCLES)) pts_master_inst (
		.clk_in(clk_in), .nrst_in(nrst_in), .link(pts_link_if_inst.master),
		.cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready_out), .cmd_kind_in(cmd_kind),
		.cmd_node_in(cmd_node), .cmd_index_in(cmd_index), .cmd_value_in(cmd_value),
		.rx_valid_out(rx_valid_out), .rx_id_out(rx_id_out), .rx_dlc_out(rx_dlc_out),
		.rx_data_out(rx_data_out));
	pts_props pts_props_inst (
		.clk(pts_link_if_inst.clk), .nrst(pts_link_if_inst.nrst),
		.m_valid(pts_link_if_inst.m_valid), .m_rtr(pts_link_if_inst.m_rtr),
		.m_id(pts_link_if_inst.m_id), .m_dlc(pts_link_if_inst.m_dlc),
		.m_data(pts_link_if_inst.m_data), .d_valid(pts_link_if_inst.d_valid),
		.d_id(pts_link_if_inst.d_id), .d_dlc(pts_link_if_inst.d_dlc),
		.d_data(pts_link_if_inst.d_data), .d_ack(pts_link_if_inst.d_ack),
		.bus_busy(pts_link_if_inst.bus_busy));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// counts received frames and remembers the last id taken off the link
	always @(posedge clk_in) begin
		if (rx_valid_out === 1'b1) begin
			rx_cnt++;
			if ((rx_id_out & 11'h780) === pts_pkg::FC_POS) pos_cnt++;
		end
		if (pts_link_if_inst.d_valid === 1'b1 && pts_link_if_inst.d_ack === 1'b1)
			lnk_id <= pts_link_if_inst.d_id;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cmd(input pts_pkg::pts_cmd_type k, input logic [6:0] nd,
		input logic [15:0] idx, input logic [31:0] val);
		int n;
		@(negedge clk_in);
		cmd_kind = k;
		cmd_node = nd;
		cmd_index = idx;
		cmd_value = val;
		cmd_valid = 1'b1;
		#1;
		for (n = 0; n < 300 && cmd_ready_out !== 1'b1; n++) begin
			@(negedge clk_in);
			#1;
		end
		chk("cmd ready", 1'b1, cmd_ready_out);
		if (cmd_ready_out !== 1'b1) stop_test();
		@(negedge clk_in);
		cmd_valid = 1'b0;
	endtask : cmd
	task automatic wait_rx(input int s);
		int n;
		for (n = 0; n < 400 && rx_cnt == s; n++) @(negedge clk_in);
		chk("rx frame", 1'b1, rx_cnt != s);
		if (rx_cnt == s) stop_test();
	endtask : wait_rx
	task automatic sdo(input logic [15:0] idx, input logic [31:0] val, input logic [7:0] cs);
		int s;
		s = rx_cnt;
		cmd(pts_pkg::PTS_CMD_SDO, cur_node, idx, val);
		wait_rx(s);
		chk("sdo id", pts_pkg::FC_SDO_TX + {4'h0, cur_node}, rx_id_out);
		chk("sdo dlc", pts_pkg::MAX_DLC, rx_dlc_out);
		chk("sdo cs", cs, rx_data_out[7:0]);
		chk("sdo index", idx, rx_data_out[23:8]);
		if (cs == pts_pkg::SDO_ABORT)
			chk("abort code", pts_pkg::SDO_ABORT_CODE, rx_data_out[63:32]);
	endtask : sdo
	task automatic nmt(input logic [6:0] target);
		cmd(pts_pkg::PTS_CMD_NMT, target, 16'h0000, 32'h0000_0000);
		repeat (20) @(negedge clk_in);
	endtask : nmt
	task automatic syncs(input int n, input int div);
		int s;
		for (int i = 1; i <= n; i++) begin
			s = pos_cnt;
			cmd(pts_pkg::PTS_CMD_SYNC, 7'h00, 16'h0000, 32'h0000_0000);
			repeat (40) @(negedge clk_in);
			chk("sync sends", (i % div) == 0, pos_cnt - s);
		end
	endtask : syncs
	task automatic t_reset();
		chk("node", 7'h20, node_out);
		chk("term", pts_pkg::TERM_RST, term_en_out);
		chk("mode", pts_pkg::PTS_POLLED, mode_out);
	endtask : t_reset
	task automatic t_polled();
		int s;
		s = pos_cnt;
		cmd(pts_pkg::PTS_CMD_SYNC, 7'h00, 16'h0000, 32'h0000_0000);
		cmd(pts_pkg::PTS_CMD_RTR, cur_node + 7'h01, 16'h0000, 32'h0000_0000);
		repeat (300) @(negedge clk_in);
		chk("unasked sends", 0, pos_cnt - s);
		s = rx_cnt;
		cmd(pts_pkg::PTS_CMD_RTR, cur_node, 16'h0000, 32'h0000_0000);
		wait_rx(s);
		chk("pos id", pts_pkg::FC_POS + {4'h0, cur_node}, rx_id_out);
		chk("pos dlc", pts_pkg::POS_DLC, rx_dlc_out);
		chk("pos data", {32'h0000_0000, pos}, rx_data_out);
		chk("link id", pts_pkg::FC_POS + {4'h0, cur_node}, lnk_id);
	endtask : t_polled
	task automatic t_config();
		sdo(pts_pkg::IDX_TERM, 32'h0000_0001, pts_pkg::SDO_ACK);
		sdo(pts_pkg::IDX_NODE, 32'h0000_007f, pts_pkg::SDO_ABORT);
		sdo(16'h1234, 32'h0000_0000, pts_pkg::SDO_ABORT);
		sdo(pts_pkg::IDX_NODE, 32'h0000_0000, pts_pkg::SDO_ACK);
		chk("term before reset", 1'b0, term_en_out);
		chk("node before reset", 7'h20, node_out);
		nmt(cur_node);
		cur_node = 7'h01;
		chk("term after reset", 1'b1, term_en_out);
		chk("node after reset", cur_node, node_out);
	endtask : t_config
	task automatic t_sync();
		sdo(pts_pkg::IDX_SYNC_DIV, 32'h0000_0003, pts_pkg::SDO_ACK);
		sdo(pts_pkg::IDX_MODE, 32'h0000_0002, pts_pkg::SDO_ACK);
		nmt(7'h00);
		chk("sync mode", pts_pkg::PTS_SYNC, mode_out);
		syncs(7, 3);
		sdo(pts_pkg::IDX_SYNC_DIV, 32'h0000_0002, pts_pkg::SDO_ACK);
		nmt(7'h00);
		syncs(2, 2);
	endtask : t_sync
	task automatic t_cyclic();
		int s;
		sdo(pts_pkg::IDX_CYCLE, 32'h0000_0002, pts_pkg::SDO_ACK);
		sdo(pts_pkg::IDX_MODE, 32'h0000_0001, pts_pkg::SDO_ACK);
		nmt(7'h00);
		s = pos_cnt;
		repeat (400) @(negedge clk_in);
		chk("cyclic count", 1'b1, (pos_cnt - s) >= 18 && (pos_cnt - s) <= 21);
	endtask : t_cyclic
	// position snapshots pass the device queue one per request, in order
	task automatic t_fifo();
		int s;
		int s0;
		s0 = pos_cnt;
		for (int i = 0; i < 3; i++) begin
			pos = 32'h0000_0100 + 32'(i);
			s = rx_cnt;
			cmd(pts_pkg::PTS_CMD_RTR, cur_node, 16'h0000, 32'h0000_0000);
			wait_rx(s);
			chk("fifo data", {32'h0000_0000, pos}, rx_data_out);
		end
		chk("fifo fill", 3, pos_cnt - s0);
		s = pos_cnt;
		repeat (100) @(negedge clk_in);
		chk("fifo empty", 0, pos_cnt - s);
	endtask : t_fifo
	initial begin
		nrst_in = 1'b0;
		cmd_valid = 1'b0;
		cmd_kind = pts_pkg::PTS_CMD_SYNC;
		cmd_node = 7'h00;
		cmd_index = 16'h0000;
		cmd_value = 32'h0000_0000;
		pos = 32'h1234_5678;
		cur_node = 7'h20;
		repeat (20) @(posedge clk_in);
		@(negedge clk_in);
		nrst_in = 1'b1;
		t_reset();
		t_polled();
		t_fifo();
		t_config();
		t_sync();
		t_cyclic();
		stop_test();
	end
endmodule : tb_top
